// >>> peripheral_irq_flag_enable_bank_tb.sv
// Self-checking bench of the flag bank over AHB-Lite
`timescale 1ns/1ps
`default_nettype none

module peripheral_irq_flag_enable_bank_tb
	import pirq_pkg::*;
;
	logic             core_clk = 1'b0;
	logic             rst, hsel, hwrite;
	logic [31:0]      haddr, hwdata, rdv;
	logic [1:0]       htrans, serLevel;
	logic [2:0]       hsize;
	logic [2:0]       busSize = HSIZE_WORD;
	logic [23:0]      busHigh = 24'h000000;
	logic             pinLevel;
	pirq_sources_type fire, src;
	wire logic        hreadyout, hresp, pinChangeAny, periphIrq, coreIrq, irqOut;
	wire logic [31:0] hrdata;
	int               n_fail, num_checks, cycles;
	logic [7:0]       offs [6] = '{OFF_EN1, OFF_EN2, OFF_EN3, OFF_REQ1, OFF_REQ2, OFF_REQ3};
	logic [7:0]       msk [6] = '{MASK_ONE, MASK_TWO, MASK_THREE, MASK_REQ1_SW, MASK_TWO, MASK_THREE};

	pirq_bank DUT (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src(src),
		.pinChangeAny(pinChangeAny), .periphIrq(periphIrq), .coreIrq(coreIrq), .irqOut(irqOut));

	pirq_periph_model PERIPH (.core_clk(core_clk), .rst(rst), .fire(fire),
		.serLevel(serLevel), .pinLevel(pinLevel), .src(src), .pinChangeAny(pinChangeAny));

	// Clock at 40 MHz
	always #12.5 core_clk = ~core_clk;

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Waits for a rising edge at which the slave shows ready
	task automatic bus_wait();
		do @(posedge core_clk); while (hreadyout !== 1'b1);
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {busHigh, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= busSize;
		bus_wait();
		htrans <= 2'h0;
		hwdata <= d;
		bus_wait();
		rdv = hrdata;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(what, exp, rdv);
		chk("okay response", 32'h00000000, {31'h0, hresp});
	endtask

	// Event pulse from the peripherals, then time to land in the flags
	task automatic pulse(input pirq_sources_type m);
		fire <= m;
		@(posedge core_clk);
		fire <= '0;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic test_regs();
		for (int i = 0; i < 6; i++)
		begin
			rd_chk("reset value", offs[i], 32'h00000000);
			bus(1'b1, offs[i], 32'h000000FF);
			rd_chk("ones written", offs[i], {24'h000000, msk[i]});
			bus(1'b1, offs[i], 32'h00000000);
			rd_chk("zeros written", offs[i], 32'h00000000);
		end
		bus(1'b1, 8'h28, 32'h000000FF);
		rd_chk("unmapped", 8'h28, 32'h00000000);
		// A byte-sized access and one above the decoded window touch nothing
		busSize = 3'h0;
		bus(1'b1, OFF_EN1, 32'h000000FF);
		busSize = HSIZE_WORD;
		busHigh = 24'h000001;
		bus(1'b1, OFF_EN1, 32'h000000FF);
		busHigh = 24'h000000;
		rd_chk("ignored writes", OFF_EN1, 32'h00000000);
		$display("test_regs done");
	endtask

	task automatic test_events();
		pulse('{8'hFF, 8'hFF, 8'hFF});
		rd_chk("req1 event", OFF_REQ1, {24'h000000, MASK_REQ1_SW});
		rd_chk("req2 event", OFF_REQ2, {24'h000000, MASK_TWO});
		rd_chk("req3 event", OFF_REQ3, {24'h000000, MASK_THREE});
		chk("periph idle", 32'h0, {31'h0, periphIrq});
		for (int i = 3; i < 6; i++)
			bus(1'b1, offs[i], 32'h00000000);
		rd_chk("req3 cleared", OFF_REQ3, 32'h00000000);
		// An event that lands in the clearing cycle must survive the clear
		fire <= '{8'h01, 8'h00, 8'h00};
		bus(1'b1, OFF_REQ3, 32'h00000000);
		fire <= '0;
		rd_chk("set beats clear", OFF_REQ3, 32'h00000001);
		bus(1'b1, OFF_REQ3, 32'h00000000);
		$display("test_events done");
	endtask

	task automatic test_serial();
		serLevel <= 2'h3;
		repeat (3) @(posedge core_clk);
		bus(1'b1, OFF_REQ1, 32'h00000000);
		rd_chk("serial held", OFF_REQ1, {24'h000000, MASK_SERIAL});
		serLevel <= 2'h0;
		repeat (3) @(posedge core_clk);
		rd_chk("serial gone", OFF_REQ1, 32'h00000000);
		$display("test_serial done");
	endtask

	task automatic test_gate();
		bus(1'b1, OFF_REQ2, 32'h00000000);
		bus(1'b1, OFF_EN2, 32'h00000001);
		pulse('{8'h00, 8'h01, 8'h00});
		chk("ungated", 32'h0, {31'h0, periphIrq});
		bus(1'b1, OFF_CTRL, 32'h00000040);
		repeat (2) @(posedge core_clk);
		chk("gated periph", 32'h1, {31'h0, periphIrq});
		chk("no global", 32'h0, {31'h0, coreIrq});
		bus(1'b1, OFF_CTRL, 32'h000000C0);
		repeat (2) @(posedge core_clk);
		chk("core request", 32'h1, {31'h0, coreIrq});
		rd_chk("status", OFF_ISTAT, 32'h00000003);
		chk("masked", 32'h0, {31'h0, irqOut});
		bus(1'b1, OFF_IEN, 32'h00000001);
		chk("irq enabled", 32'h1, {31'h0, irqOut});
		rd_chk("bank enable", OFF_IEN, 32'h00000001);
		bus(1'b1, OFF_ICLR, 32'h00000003);
		chk("irq cleared", 32'h0, {31'h0, irqOut});
		rd_chk("clear reads zero", OFF_ICLR, 32'h00000000);
		rd_chk("status cleared", OFF_ISTAT, 32'h00000000);
		bus(1'b1, OFF_REQ2, 32'h00000000);
		repeat (2) @(posedge core_clk);
		chk("request dropped", 32'h0, {31'h0, periphIrq});
		$display("test_gate done");
	endtask

	task automatic test_summary();
		pinLevel <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd_chk("summary set", OFF_CTRL, 32'h000000C1);
		bus(1'b1, OFF_CTRL, 32'h00000000);
		rd_chk("summary read-only", OFF_CTRL, 32'h00000001);
		pinLevel <= 1'b0;
		repeat (3) @(posedge core_clk);
		rd_chk("summary clear", OFF_CTRL, 32'h00000000);
		$display("test_summary done");
	endtask

	task automatic test_reset();
		bus(1'b1, OFF_EN1, 32'h000000FF);
		rst <= 1'b1;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd_chk("second reset", OFF_EN1, 32'h00000000);
		$display("test_reset done");
	endtask

	// Main sequence
	initial
	begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h00000000;
		fire = '0;
		serLevel = 2'h0;
		pinLevel = 1'b0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		test_regs();
		test_events();
		test_serial();
		test_gate();
		test_summary();
		test_reset();
		finish_test();
	end
endmodule

`default_nettype wire

// >>> pirq_ahb_front.sv
// AHB-Lite address phase capture and ready generation for the flag bank
`timescale 1ns/1ps
`default_nettype none

module pirq_ahb_front
	import pirq_pkg::*;
(
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// AHB-Lite address phase
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic                 hready,
	// Registered access strobe and ready
	output var  pirq_front_state_type state
);

	pirq_front_state_type next_state;
	logic                 accept;
	logic                 valid;

	// Every accepted transfer gets one wait state so read data can come from a flop
	always_comb
	begin
		accept = hready && hsel && htrans[HTRANS_ACTIVE_BIT];
		valid = (hsize == HSIZE_WORD) && (haddr[31:OFFSET_BITS] == '0);
		next_state = state;
		next_state.strobe = 1'b0;
		next_state.readyOut = 1'b1;
		if (accept)
		begin
			// Odd sizes and far addresses still finish OKAY, but touch nothing
			next_state.strobe = valid;
			next_state.write = hwrite;
			next_state.addr = haddr[OFFSET_BITS-1:0];
			next_state.readyOut = 1'b0;
		end
	end

	// State register
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			state <= FRONT_RESET;
		else
			state <= next_state;
	end

endmodule

`default_nettype wire

// >>> pirq_bank.sv
// Peripheral interrupt flag and enable bank with AHB-Lite register access
//
// Notes on behaviour
// R1: Source events set flags regardless of enables
// R2: Software clears a flag before enabling it
// R3: No peripheral request without the gate bit
// R4: Enable three: oscillator, shutdown, zero-cross, cells
// R5: Request three uses enable three bit positions
// R6: Request one holds the eight documented sources
// R7: Serial flags read-only, follow serial port
// R8: Request two holds oscillator, comparators, timers, capture
// R9: Flag reads one while its interrupt pends
// R10: All enable and request bits reset zero
// R11: Unimplemented positions always read zero
// R12: Pin-change summary read-only, follows pin flags
// R13: Enables one and two mirror request positions
// R14: Request is any enabled flag, gated, qualified
`timescale 1ns/1ps
`default_nettype none

module pirq_bank
	import pirq_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// Peripheral flag sources, same clock
	input  wire pirq_sources_type  src,
	input  wire logic              pinChangeAny,
	// Requests toward the core and the bank interrupt
	output logic                   periphIrq,
	output logic                   coreIrq,
	output logic                   irqOut
);

	pirq_front_state_type access;
	pirq_bank_state_type  state;
	pirq_bank_state_type  next_state;
	logic                 wrStrobe;
	logic                 rdStrobe;
	logic [7:0]           wrByte;
	logic                 anyPending;
	logic [EVT_WIDTH-1:0] events;
	logic [EVT_WIDTH-1:0] clearBits;

	// Address phase capture and wait-state generation
	pirq_ahb_front u_front (
		.core_clk (core_clk),
		.rst      (rst),
		.hsel     (hsel),
		.haddr    (haddr),
		.htrans   (htrans),
		.hwrite   (hwrite),
		.hsize    (hsize),
		.hready   (hready),
		.state    (access)
	);

	// Address match, shared by write decode and the read mux
	function automatic logic isReg(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// Read mux; unmapped offsets and the clear register read as zero
	function automatic logic [31:0] readReg(input pirq_bank_state_type s,
		input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (isReg(a, OFF_CTRL))
			v[7:0] = {s.ctrlGlobal, s.ctrlGate, 5'h00, s.summary};
		else if (isReg(a, OFF_EN1))
			v[7:0] = s.en1;
		else if (isReg(a, OFF_EN2))
			v[7:0] = s.en2 & MASK_TWO; // see R11
		else if (isReg(a, OFF_EN3))
			v[7:0] = s.en3 & MASK_THREE; // see R11
		else if (isReg(a, OFF_REQ1))
			v[7:0] = s.req1; // see R9
		else if (isReg(a, OFF_REQ2))
			v[7:0] = s.req2 & MASK_TWO; // see R9
		else if (isReg(a, OFF_REQ3))
			v[7:0] = s.req3 & MASK_THREE; // see R9
		else if (isReg(a, OFF_ISTAT))
			v[EVT_WIDTH-1:0] = s.istat;
		else if (isReg(a, OFF_IEN))
			v[EVT_WIDTH-1:0] = s.ien;
		return v;
	endfunction

	// Access decode; write data stands on hwdata during the strobe cycle
	assign wrStrobe = access.strobe && access.write;
	assign rdStrobe = access.strobe && !access.write;
	assign wrByte = hwdata[7:0];

	// Next state of the whole bank
	always_comb
	begin
		next_state = state;
		clearBits = '0;

		// Control: global and gate bits writable, summary tracks the pin block
		if (wrStrobe && isReg(access.addr, OFF_CTRL))
		begin
			next_state.ctrlGlobal = wrByte[CTRL_GLOBAL_BIT];
			next_state.ctrlGate = wrByte[CTRL_GATE_BIT];
		end
		next_state.summary = pinChangeAny; // see R12

		// Enables share the bit layout of their request registers
		if (wrStrobe && isReg(access.addr, OFF_EN1))
			next_state.en1 = wrByte & MASK_ONE; // see R13
		if (wrStrobe && isReg(access.addr, OFF_EN2))
			next_state.en2 = wrByte & MASK_TWO; // see R13
		if (wrStrobe && isReg(access.addr, OFF_EN3))
			next_state.en3 = wrByte & MASK_THREE; // see R4

		// Request one: software owns six bits, serial port owns two
		if (wrStrobe && isReg(access.addr, OFF_REQ1))
			next_state.req1 = wrByte & MASK_REQ1_SW; // see R6
		// A source event in the clearing cycle still leaves its flag set
		next_state.req1 = (next_state.req1 & MASK_REQ1_SW)
			| (src.one & MASK_REQ1_SW) // see R1
			| (src.one & MASK_SERIAL); // see R7

		// Request two and three: writable, events win over a software clear
		if (wrStrobe && isReg(access.addr, OFF_REQ2))
			next_state.req2 = wrByte;
		next_state.req2 = (next_state.req2 | src.two) & MASK_TWO; // see R8
		if (wrStrobe && isReg(access.addr, OFF_REQ3))
			next_state.req3 = wrByte;
		next_state.req3 = (next_state.req3 | src.three) & MASK_THREE; // see R5

		// Peripheral request and core request from the present flags
		anyPending = |(state.req1 & state.en1) | |(state.req2 & state.en2)
			| |(state.req3 & state.en3); // see R14
		next_state.periphIrq = state.ctrlGate && anyPending; // see R3
		next_state.coreIrq = next_state.periphIrq && state.ctrlGlobal; // see R14

		// Bank events: rising edges of the two requests
		events = '0;
		events[EVT_PERIPH_BIT] = next_state.periphIrq && !state.periphIrq;
		events[EVT_CORE_BIT] = next_state.coreIrq && !state.coreIrq;
		if (wrStrobe && isReg(access.addr, OFF_ICLR))
			clearBits = wrByte[EVT_WIDTH-1:0];
		// Set beats clear so an edge during the clear is never lost
		next_state.istat = (state.istat & ~clearBits) | events;
		if (wrStrobe && isReg(access.addr, OFF_IEN))
			next_state.ien = wrByte[EVT_WIDTH-1:0];
		next_state.irqOut = |(next_state.istat & next_state.ien);

		// Read data is latched for the second data-phase cycle
		if (rdStrobe)
			next_state.rdata = readReg(state, access.addr); // see R9
	end

	// State register; one reset covers power-on, brown-out and all others
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			state <= BANK_RESET; // see R10
		else
			state <= next_state;
	end

	// Outputs straight from flops; every response is OKAY
	assign hreadyout = access.readyOut;
	assign hresp = 1'b0;
	assign hrdata = state.rdata;
	assign periphIrq = state.periphIrq;
	assign coreIrq = state.coreIrq;
	assign irqOut = state.irqOut;

	// Helper terms read only by the checks below
	logic [7:0] srcOneMasked;
	logic [7:0] srcTwoMasked;
	logic [7:0] srcThreeMasked;
	logic [1:0] serialLevel;
	logic       wrEnOne;
	logic       wrEnThree;
	logic       rdReqOne;
	logic       gatedPending;
	logic       wrEnTwo;
	logic       wrReqTwo;
	logic       wrCtrl;
	logic       busAccept;
	assign srcOneMasked = src.one & MASK_REQ1_SW;
	assign srcTwoMasked = src.two & MASK_TWO;
	assign srcThreeMasked = src.three & MASK_THREE;
	assign serialLevel = {src.one[SERIAL_RX_BIT], src.one[SERIAL_TX_BIT]};
	assign wrEnOne = wrStrobe && isReg(access.addr, OFF_EN1);
	assign wrEnThree = wrStrobe && isReg(access.addr, OFF_EN3);
	assign rdReqOne = rdStrobe && isReg(access.addr, OFF_REQ1);
	assign gatedPending = state.ctrlGate && anyPending;
	assign wrEnTwo = wrStrobe && isReg(access.addr, OFF_EN2);
	assign wrReqTwo = wrStrobe && isReg(access.addr, OFF_REQ2);
	assign wrCtrl = wrStrobe && isReg(access.addr, OFF_CTRL);
	assign busAccept = hready && hsel && htrans[HTRANS_ACTIVE_BIT];

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// Events set flags even while a write clears the same register
	property p_set_one;
		(srcOneMasked != 8'h00) |=> ((state.req1 & $past(srcOneMasked)) == $past(srcOneMasked));
	endproperty
	a_set_one: assert property (p_set_one) // see R1
		else $error("request one flag not set by its source");

	property p_set_three;
		(srcThreeMasked != 8'h00)
			|=> ((state.req3 & $past(srcThreeMasked)) == $past(srcThreeMasked));
	endproperty
	a_set_three: assert property (p_set_three) // see R1
		else $error("request three flag not set by its source");

	property p_set_two;
		(srcTwoMasked != 8'h00) |=> ((state.req2 & $past(srcTwoMasked)) == $past(srcTwoMasked));
	endproperty
	a_set_two: assert property (p_set_two) // see R8
		else $error("request two flag not set by its source");

	property p_gate_off;
		!state.ctrlGate |=> !periphIrq && !coreIrq;
	endproperty
	a_gate_off: assert property (p_gate_off) // see R3
		else $error("peripheral request without gate bit");

	property p_request_on;
		gatedPending |=> periphIrq ##0 (coreIrq == $past(state.ctrlGlobal));
	endproperty
	a_request_on: assert property (p_request_on) // see R14
		else $error("enabled pending flag did not raise the request");

	property p_no_pending;
		!anyPending |=> !periphIrq;
	endproperty
	a_no_pending: assert property (p_no_pending) // see R14
		else $error("request raised with nothing enabled and pending");

	property p_serial;
		1'b1 |=> (state.req1[SERIAL_RX_BIT:SERIAL_TX_BIT] == $past(serialLevel));
	endproperty
	a_serial: assert property (p_serial) // see R7
		else $error("serial flags do not follow the serial port");

	property p_unused_zero;
		!state.req3[7] && !state.en3[7] && !state.req2[4] && !state.en2[4];
	endproperty
	a_unused_zero: assert property (p_unused_zero) // see R11
		else $error("unimplemented bit holds a one");

	property p_summary;
		1'b1 |=> (state.summary == $past(pinChangeAny));
	endproperty
	a_summary: assert property (p_summary) // see R12
		else $error("pin-change summary does not follow the pin flags");

	property p_reset_zero;
		$fell(rst) |-> (state.req1 == 8'h00) && (state.req2 == 8'h00)
			&& (state.req3 == 8'h00) && (state.en1 == 8'h00)
			&& (state.en2 == 8'h00) && (state.en3 == 8'h00);
	endproperty
	a_reset_zero: assert property (p_reset_zero) // see R10
		else $error("flag or enable not zero after reset");

	property p_write_en_one;
		wrEnOne |=> (state.en1 == $past(wrByte));
	endproperty
	a_write_en_one: assert property (p_write_en_one) // see R13
		else $error("enable one write not stored");

	property p_write_en_three;
		wrEnThree |=> (state.en3 == ($past(wrByte) & MASK_THREE));
	endproperty
	a_write_en_three: assert property (p_write_en_three) // see R4
		else $error("enable three write not stored");

	property p_read_req_one;
		rdReqOne |=> (hrdata == {24'h000000, $past(state.req1)}) ##0 hreadyout;
	endproperty
	a_read_req_one: assert property (p_read_req_one) // see R9
		else $error("request one read returned wrong data");

	property p_write_en_two;
		wrEnTwo |=> (state.en2 == ($past(wrByte) & MASK_TWO));
	endproperty
	a_write_en_two: assert property (p_write_en_two) // see R13
		else $error("enable two write not stored");

	property p_write_req_two;
		wrReqTwo && (srcTwoMasked == 8'h00) |=> (state.req2 == ($past(wrByte) & MASK_TWO));
	endproperty
	a_write_req_two: assert property (p_write_req_two) // see R8
		else $error("request two write not stored");

	property p_ctrl_write;
		wrCtrl |=> (state.ctrlGate == $past(wrByte[CTRL_GATE_BIT]))
			&& (state.ctrlGlobal == $past(wrByte[CTRL_GLOBAL_BIT]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) // see R3
		else $error("control gate or global bit not stored");

	property p_core_global;
		!state.ctrlGlobal |=> !coreIrq;
	endproperty
	a_core_global: assert property (p_core_global) // see R14
		else $error("core request without global enable");

	property p_core_follows;
		coreIrq |-> periphIrq;
	endproperty
	a_core_follows: assert property (p_core_follows) // see R14
		else $error("core request without peripheral request");

	// Bus timing and bank interrupt; a lost wait state would hand back stale read data
	property p_one_wait;
		busAccept |=> !hreadyout ##1 hreadyout;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("transfer did not take exactly one wait state");

	property p_status_periph;
		$rose(periphIrq) |-> state.istat[EVT_PERIPH_BIT];
	endproperty
	a_status_periph: assert property (p_status_periph)
		else $error("rising request not recorded in bank status");

	property p_irq_out;
		irqOut == |(state.istat & state.ien);
	endproperty
	a_irq_out: assert property (p_irq_out)
		else $error("bank interrupt does not match enabled status");

	// Main scenarios
	c_core_request: cover property ($rose(coreIrq));
	c_set_during_clear: cover property (wrStrobe && isReg(access.addr, OFF_REQ3)
		&& (srcThreeMasked != 8'h00));
	c_bank_irq: cover property ($rose(irqOut));
	c_read_flags: cover property (rdReqOne ##1 (hrdata != 32'h0000_0000));
	c_ignored_size: cover property (busAccept && (hsize != HSIZE_WORD));

endmodule

`default_nettype wire

// >>> pirq_periph_model.sv
// Behavioural model of the peripheral units that raise flag conditions
`timescale 1ns/1ps
`default_nettype none

module pirq_periph_model
	import pirq_pkg::*;
(
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Commands from the bench
	input  wire pirq_sources_type fire,
	input  wire logic [1:0]       serLevel,
	input  wire logic             pinLevel,
	// Conditions toward the bank
	output var  pirq_sources_type src,
	output var  logic             pinChangeAny
);
	logic toggle;

	// Events follow the bench commands one cycle later; unused positions toggle so a leak shows
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			toggle       <= 1'b0;
			src          <= '0;
			pinChangeAny <= 1'b0;
		end
		else
		begin
			toggle       <= ~toggle;
			src.one      <= {fire.one[7:6], serLevel, fire.one[3:0]};
			src.two      <= {fire.two[7:5], toggle, fire.two[3:0]};
			src.three    <= {toggle, fire.three[6:0]};
			pinChangeAny <= pinLevel;
		end
	end
endmodule

`default_nettype wire

// >>> pirq_pkg.sv
// Constants, layouts and carrier types of the peripheral interrupt flag bank
`default_nettype none

package pirq_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_EN1   = 8'h04;
	localparam logic [7:0] OFF_EN2   = 8'h08;
	localparam logic [7:0] OFF_EN3   = 8'h0C;
	localparam logic [7:0] OFF_REQ1  = 8'h10;
	localparam logic [7:0] OFF_REQ2  = 8'h14;
	localparam logic [7:0] OFF_REQ3  = 8'h18;
	localparam logic [7:0] OFF_ISTAT = 8'h1C;
	localparam logic [7:0] OFF_ICLR  = 8'h20;
	localparam logic [7:0] OFF_IEN   = 8'h24;

	// Decoded address window; higher address bits must be zero
	localparam int OFFSET_BITS = 8;

	// Control register field positions
	localparam int CTRL_GLOBAL_BIT  = 7;
	localparam int CTRL_GATE_BIT    = 6;
	localparam int CTRL_SUMMARY_BIT = 0;

	// Request register 1: 7 timer1 gate, 6 conversion, 5 serial rx, 4 serial tx,
	// 3 sync serial, 2 capture unit 1, 1 timer2 match, 0 timer1 overflow
	localparam int SERIAL_RX_BIT = 5;
	localparam int SERIAL_TX_BIT = 4;
	localparam logic [7:0] MASK_SERIAL  = 8'h30;
	localparam logic [7:0] MASK_REQ1_SW = 8'hCF;
	localparam logic [7:0] MASK_ONE     = 8'hFF;

	// Register 2: 7 osc fail, 6 comparator 2, 5 comparator 1, 4 unused,
	// 3 bus collision, 2 timer6 match, 1 timer4 match, 0 capture unit 2
	localparam logic [7:0] MASK_TWO = 8'hEF;

	// Register 3: 7 unused, 6 numeric osc, 5 shutdown, 4 zero cross, 3..0 cells 4..1
	localparam logic [7:0] MASK_THREE = 8'h7F;

	// Bank event status bits
	localparam int EVT_WIDTH      = 2;
	localparam int EVT_PERIPH_BIT = 0;
	localparam int EVT_CORE_BIT   = 1;

	// AHB transfer type bit that marks an active transfer, and the word size
	localparam int         HTRANS_ACTIVE_BIT = 1;
	localparam logic [2:0] HSIZE_WORD        = 3'h2;

	// Flag sources from the peripherals; one[5:4] are serial pending levels
	typedef struct packed {
		logic [7:0] three;
		logic [7:0] two;
		logic [7:0] one;
	} pirq_sources_type;

	// Front end state, doubles as the access strobe to the bank
	typedef struct packed {
		logic       strobe;
		logic       write;
		logic [7:0] addr;
		logic       readyOut;
	} pirq_front_state_type;

	// Complete state of the flag bank
	typedef struct packed {
		logic                 ctrlGlobal;
		logic                 ctrlGate;
		logic                 summary;
		logic [7:0]           en1;
		logic [7:0]           en2;
		logic [7:0]           en3;
		logic [7:0]           req1;
		logic [7:0]           req2;
		logic [7:0]           req3;
		logic [EVT_WIDTH-1:0] istat;
		logic [EVT_WIDTH-1:0] ien;
		logic                 periphIrq;
		logic                 coreIrq;
		logic                 irqOut;
		logic [31:0]          rdata;
	} pirq_bank_state_type;

	// Values after reset
	localparam pirq_front_state_type FRONT_RESET = '{1'b0, 1'b0, 8'h00, 1'b1};
	localparam pirq_bank_state_type  BANK_RESET  = '0;

endpackage

`default_nettype wire
